// ---- logic/phc_pkg.sv ----
package phc_pkg;

	// ----------------------------------------
	// apb register map
	// ----------------------------------------
	localparam int unsigned APB_AW = 12;

	// printed offsets include 4F, which is not word aligned, so they serve as word indices
	localparam logic [7:0] ARB_CTRL_IDX    = 8'h4F;
	localparam logic [7:0] PCI_FEAT_IDX    = 8'h50;
	localparam logic [7:0] ARB_STATUS_IDX  = 8'h60;
	localparam logic [1:0] WORD_ALIGN      = 2'h0;

	localparam logic [APB_AW-1:0] ARB_CTRL_ADDR   = {2'h0, ARB_CTRL_IDX, WORD_ALIGN};
	localparam logic [APB_AW-1:0] PCI_FEAT_ADDR   = {2'h0, PCI_FEAT_IDX, WORD_ALIGN};
	localparam logic [APB_AW-1:0] ARB_STATUS_ADDR = {2'h0, ARB_STATUS_IDX, WORD_ALIGN};

	// ----------------------------------------
	// fields and reset values
	// ----------------------------------------
	localparam int unsigned EXT_HOLD_ACK_BIT = 7;
	localparam int unsigned CONC_EN_BIT      = 3;
	localparam int unsigned STAT_HOLD_OFF    = 0;
	localparam int unsigned STAT_EXT_ACTIVE  = 1;

	localparam logic [7:0] ARB_CTRL_RST  = 8'h00;
	localparam logic [7:0] PCI_FEAT_RST  = 8'h00;
	localparam logic [7:0] ARB_CTRL_MASK = 8'h80;
	localparam logic [7:0] PCI_FEAT_MASK = 8'h08;
	localparam logic [31:0] RDATA_RST    = 32'h0000_0000;

	// ----------------------------------------
	// hold-acknowledge shaper states
	// ----------------------------------------
	typedef enum logic [1:0] {
		HS_IDLE,
		HS_ADDR,
		HS_LOCK
	} phc_hold_e;

endpackage

// ---- logic/phc_hold_if.sv ----
`timescale 1ns/1ps
interface phc_hold_if;
	logic ext_en;
	logic addr_next;
	logic cpu_lock;
	logic pci_lock_n;
	logic base_hold_ack_n;
	logic hold_acknowledge_n;
	logic ext_active;

	modport ctrl (
		output ext_en,
		output addr_next,
		output cpu_lock,
		output pci_lock_n,
		output base_hold_ack_n,
		input  hold_acknowledge_n,
		input  ext_active
	);

	modport shaper (
		input  ext_en,
		input  addr_next,
		input  cpu_lock,
		input  pci_lock_n,
		input  base_hold_ack_n,
		output hold_acknowledge_n,
		output ext_active
	);
endinterface

// ---- logic/phc_hold_shaper.sv ----
`timescale 1ns/1ps
module phc_hold_shaper
	import phc_pkg::*;
(
	input  wire logic  core_clk,
	input  wire logic  rst,
	input  wire logic  ce,
	phc_hold_if.shaper hif
);
	import phc_pkg::*;

	phc_hold_e state_q;
	phc_hold_e state_d;
	logic      hold_ack_n_q;
	logic      hold_ack_n_d;

	// ----------------------------------------
	// extra acknowledge sequencing
	// ----------------------------------------
	always_comb begin
		state_d = state_q;
		case (state_q)
			HS_IDLE: begin
				if (hif.ext_en && hif.addr_next) begin
					state_d = HS_ADDR; // [RULE_01]
				end
			end
			HS_ADDR: begin
				// lock counts as established only if lock was seen negated here
				if (hif.cpu_lock && hif.pci_lock_n) begin
					state_d = HS_LOCK; // [RULE_02]
				end else if (hif.ext_en && hif.addr_next) begin
					state_d = HS_ADDR;
				end else begin
					state_d = HS_IDLE;
				end
			end
			HS_LOCK: begin
				if (hif.ext_en && hif.addr_next) begin
					state_d = HS_ADDR;
				end else begin
					state_d = HS_IDLE;
				end
			end
			default: begin
				state_d = HS_IDLE;
			end
		endcase
		// extra pulse is or-ed onto the normal acknowledge, active low
		hold_ack_n_d = hif.base_hold_ack_n && (state_d == HS_IDLE); // [RULE_01] [RULE_02]
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			state_q      <= HS_IDLE;
			hold_ack_n_q <= 1'b1;
		end else if (ce) begin
			state_q      <= state_d;
			hold_ack_n_q <= hold_ack_n_d;
		end
	end

	assign hif.hold_acknowledge_n = hold_ack_n_q;
	assign hif.ext_active         = (state_q != HS_IDLE);

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_addr_phase_pulse: assert property (ce && hif.ext_en && hif.addr_next |=> !hif.hold_acknowledge_n) // [RULE_01]
		else $error("no acknowledge pulse in address phase");
	a_lock_extra_clock: assert property (ce && state_q == HS_ADDR && hif.cpu_lock && hif.pci_lock_n
		|=> state_q == HS_LOCK && !hif.hold_acknowledge_n) // [RULE_02]
		else $error("acknowledge not extended after locked address phase");
	a_no_unlocked_ext: assert property (ce && state_q == HS_ADDR && !(hif.cpu_lock && hif.pci_lock_n)
		|=> state_q != HS_LOCK) // [RULE_02]
		else $error("acknowledge extended without established lock");
	a_lock_one_only: assert property (ce && state_q == HS_LOCK |=> state_q != HS_LOCK) // [RULE_02]
		else $error("lock extension longer than one clock");
	a_disabled_pass: assert property (ce && !hif.ext_en && state_q == HS_IDLE
		|=> hif.hold_acknowledge_n == $past(hif.base_hold_ack_n)) // [RULE_01]
		else $error("extra acknowledge while extension disabled");

	c_locked_ext: cover property (state_q == HS_ADDR ##1 state_q == HS_LOCK);
endmodule

// ---- logic/phc_ctrl.sv ----
// How it works
// [RULE_01] With extended hold acknowledge on, every bridge PCI transaction gets acknowledge low for its address phase.
// [RULE_02] With extended signalling on and a locked CPU cycle whose lock was seen free, acknowledge stays one more clock.
// [RULE_03] Software sets the extension bit whenever passive release and delayed transactions are on in the south bridge.
// [RULE_04] Software keeps the south bridge's matching bit set first on enable and cleared last on disable.
// [RULE_05] With concurrency on, the CPU keeps DRAM and L2 while a non-south-bridge master talks to peer devices.
// [RULE_06] With concurrency off, the reset state, the CPU is held off for the whole of every PCI master cycle.
// [RULE_07] Firmware is expected to set the concurrency bit during normal operation.
// [RULE_08] Reserved bits of both control registers read zero and ignore writes.
//
// The APB register port is this design's own decision.
`timescale 1ns/1ps
module phc_ctrl
	import phc_pkg::*;
(
	input  wire logic                core_clk,
	input  wire logic                rst,
	input  wire logic                ce,
	// apb slave
	input  wire logic                psel,
	input  wire logic                penable,
	input  wire logic                pwrite,
	input  wire logic [APB_AW-1:0]   paddr,
	input  wire logic [31:0]         pwdata,
	input  wire logic [3:0]          pstrb,
	output logic                     pready,
	output logic [31:0]              prdata,
	output logic                     pslverr,
	// hold handshake with the south bridge
	input  wire logic                base_hold_ack_n,
	input  wire logic                addr_next,
	input  wire logic                cpu_lock,
	input  wire logic                pci_lock_n,
	output logic                     hold_acknowledge_n,
	// cpu concurrency
	input  wire logic                pci_master_active,
	input  wire logic                master_is_south,
	input  wire logic                target_is_peer,
	output logic                     cpu_hold_off
);
	import phc_pkg::*;

	phc_hold_if hif ();

	logic [7:0]  arb_ctrl_q;
	logic [7:0]  arb_ctrl_d;
	logic [7:0]  pci_feat_q;
	logic [7:0]  pci_feat_d;
	logic [31:0] prdata_q;
	logic [31:0] prdata_d;
	logic        slverr_q;
	logic        slverr_d;
	logic        loaded_q;
	logic        loaded_d;
	logic        hold_off_q;
	logic        hold_off_d;
	logic        wr_en;

	function automatic logic addr_mapped(input logic [APB_AW-1:0] a);
		return (a == ARB_CTRL_ADDR) || (a == PCI_FEAT_ADDR) || (a == ARB_STATUS_ADDR);
	endfunction

	function automatic logic [31:0] read_mux(input logic [APB_AW-1:0] a, input logic [7:0] arb,
		input logic [7:0] feat, input logic [7:0] stat);
		logic [31:0] r;
		r = RDATA_RST;
		if (a == ARB_CTRL_ADDR) begin
			r[7:0] = arb & ARB_CTRL_MASK; // [RULE_08]
		end else if (a == PCI_FEAT_ADDR) begin
			r[7:0] = feat & PCI_FEAT_MASK; // [RULE_08]
		end else if (a == ARB_STATUS_ADDR) begin
			r[7:0] = stat;
		end
		return r;
	endfunction

	// ----------------------------------------
	// apb slave
	// ----------------------------------------
	// one setup cycle with ce loads the answer; a frozen clock enable stretches the wait
	assign pready  = ce && loaded_q;
	assign prdata  = prdata_q;
	assign pslverr = slverr_q;
	assign wr_en   = psel && penable && pready && pwrite && pstrb[0];

	logic [7:0] status_w;
	always_comb begin
		status_w                  = 8'h00;
		status_w[STAT_HOLD_OFF]   = hold_off_q;
		status_w[STAT_EXT_ACTIVE] = hif.ext_active;
	end

	always_comb begin
		loaded_d = psel && !(penable && pready);
		prdata_d = prdata_q;
		slverr_d = slverr_q;
		if (psel) begin
			prdata_d = pwrite ? RDATA_RST : read_mux(paddr, arb_ctrl_q, pci_feat_q, status_w);
			slverr_d = !addr_mapped(paddr);
		end
		arb_ctrl_d = arb_ctrl_q;
		pci_feat_d = pci_feat_q;
		if (wr_en && paddr == ARB_CTRL_ADDR) begin
			// software orders this against the south bridge's matching bit
			arb_ctrl_d = pwdata[7:0] & ARB_CTRL_MASK; // [RULE_04] [RULE_08]
		end
		if (wr_en && paddr == PCI_FEAT_ADDR) begin
			pci_feat_d = pwdata[7:0] & PCI_FEAT_MASK; // [RULE_07] [RULE_08]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			arb_ctrl_q <= ARB_CTRL_RST;
			pci_feat_q <= PCI_FEAT_RST;
			prdata_q   <= RDATA_RST;
			slverr_q   <= 1'b0;
			loaded_q   <= 1'b0;
		end else if (ce) begin
			arb_ctrl_q <= arb_ctrl_d;
			pci_feat_q <= pci_feat_d;
			prdata_q   <= prdata_d;
			slverr_q   <= slverr_d;
			loaded_q   <= loaded_d;
		end
	end

	// ----------------------------------------
	// hold acknowledge shaping
	// ----------------------------------------
	assign hif.ext_en          = arb_ctrl_q[EXT_HOLD_ACK_BIT]; // [RULE_03]
	assign hif.addr_next       = addr_next;
	assign hif.cpu_lock        = cpu_lock;
	assign hif.pci_lock_n      = pci_lock_n;
	assign hif.base_hold_ack_n = base_hold_ack_n;
	assign hold_acknowledge_n  = hif.hold_acknowledge_n;

	phc_hold_shaper u_shaper (
		.core_clk (core_clk),
		.rst      (rst),
		.ce       (ce),
		.hif      (hif.shaper)
	);

	// ----------------------------------------
	// cpu concurrency
	// ----------------------------------------
	// south bridge masters and dram targets always stall the cpu, concurrency or not
	always_comb begin
		hold_off_d = pci_master_active; // [RULE_06]
		if (pci_feat_q[CONC_EN_BIT] && !master_is_south && target_is_peer) begin
			hold_off_d = 1'b0; // [RULE_05]
		end
	end

	always_ff @(posedge core_clk or posedge rst) begin
		if (rst) begin
			hold_off_q <= 1'b0;
		end else if (ce) begin
			hold_off_q <= hold_off_d;
		end
	end

	assign cpu_hold_off = hold_off_q;

	// ----------------------------------------
	// checks
	// ----------------------------------------
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (rst);

	a_hold_off_all: assert property (ce && pci_master_active && !pci_feat_q[CONC_EN_BIT] |=> cpu_hold_off) // [RULE_06]
		else $error("cpu not held off during master cycle");
	a_conc_release: assert property (ce && pci_feat_q[CONC_EN_BIT] && pci_master_active && !master_is_south
		&& target_is_peer |=> !cpu_hold_off) // [RULE_05]
		else $error("cpu held off during peer concurrency");
	a_south_holds: assert property (ce && pci_master_active && master_is_south |=> cpu_hold_off) // [RULE_05]
		else $error("south bridge master did not hold off cpu");
	a_rsvd_read_zero: assert property (psel && penable && pready && !pwrite && paddr == ARB_CTRL_ADDR
		|-> prdata[6:0] == 7'h00 && prdata[31:8] == 24'h000000) // [RULE_08]
		else $error("reserved bits of arbitration control read nonzero");
	a_feat_write: assert property (ce && wr_en && paddr == PCI_FEAT_ADDR
		|=> pci_feat_q == (PCI_FEAT_MASK & $past(pwdata[7:0]))) // [RULE_08]
		else $error("feature control write not stored as masked");
	a_ext_bit_write: assert property (ce && wr_en && paddr == ARB_CTRL_ADDR
		|=> hif.ext_en == $past(pwdata[EXT_HOLD_ACK_BIT])) // [RULE_03]
		else $error("extension enable did not follow write");

	c_conc_peer: cover property (pci_feat_q[CONC_EN_BIT] && pci_master_active && !cpu_hold_off);
	c_ext_pulse: cover property (hif.ext_en && addr_next ##1 !hold_acknowledge_n);
	c_unmapped: cover property (psel && penable && pready && pslverr);
endmodule

// ---- dv/phc_far_end.sv ----
`timescale 1ns/1ps
module phc_far_end (
	input  wire logic core_clk,
	input  wire logic hold_acknowledge_n,
	output logic      base_hold_ack_n,
	output logic      addr_next,
	output logic      cpu_lock,
	output logic      pci_lock_n,
	output logic      pci_master_active,
	output logic      master_is_south,
	output logic      target_is_peer
);
	// ----------------------------------------
	// idle levels
	// ----------------------------------------
	initial begin
		base_hold_ack_n   = 1'b1;
		addr_next         = 1'b0;
		cpu_lock          = 1'b0;
		pci_lock_n        = 1'b0;
		pci_master_active = 1'b0;
		master_is_south   = 1'b0;
		target_is_peer    = 1'b0;
	end

	// ----------------------------------------
	// bridge transaction, acknowledge seen in three cycles
	// ----------------------------------------
	task automatic bridge_cycle(input logic lk, input logic free, output logic [2:0] seen);
		@(posedge core_clk);
		addr_next <= 1'b1;
		@(posedge core_clk);
		addr_next  <= 1'b0;
		cpu_lock   <= lk;
		pci_lock_n <= free;
		#1 seen[0] = hold_acknowledge_n;
		@(posedge core_clk);
		// lock only matters in the address phase, so flip it afterwards
		cpu_lock   <= 1'b0;
		pci_lock_n <= ~free;
		#1 seen[1] = hold_acknowledge_n;
		@(posedge core_clk);
		#1 seen[2] = hold_acknowledge_n;
	endtask

	// ----------------------------------------
	// other pci master, result visible one cycle later
	// ----------------------------------------
	task automatic master_cycle(input logic act, input logic south, input logic peer);
		@(posedge core_clk);
		pci_master_active <= act;
		master_is_south   <= south;
		target_is_peer    <= peer;
		@(posedge core_clk);
		#1;
	endtask
endmodule

// ---- dv/pci_hold_ack_concurrency_ctrl_test.sv ----
`timescale 1ns/1ps
module pci_hold_ack_concurrency_ctrl_test;
	import phc_pkg::*;
	logic              core_clk, rst, ce, psel, penable, pwrite, pready, pslverr, err;
	logic [APB_AW-1:0] paddr;
	logic [31:0]       pwdata, prdata, q;
	logic [3:0]        pstrb;
	logic              base_hold_ack_n, addr_next, cpu_lock, pci_lock_n, hold_acknowledge_n;
	logic              pci_master_active, master_is_south, target_is_peer, cpu_hold_off;
	logic [2:0]        s;
	int                errors, n_checks, i;

	phc_ctrl u_dut (.core_clk(core_clk), .rst(rst), .ce(ce), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr), .base_hold_ack_n(base_hold_ack_n), .addr_next(addr_next),
		.cpu_lock(cpu_lock), .pci_lock_n(pci_lock_n), .hold_acknowledge_n(hold_acknowledge_n),
		.pci_master_active(pci_master_active), .master_is_south(master_is_south),
		.target_is_peer(target_is_peer), .cpu_hold_off(cpu_hold_off));

	phc_far_end u_far (.core_clk(core_clk), .hold_acknowledge_n(hold_acknowledge_n),
		.base_hold_ack_n(base_hold_ack_n), .addr_next(addr_next), .cpu_lock(cpu_lock),
		.pci_lock_n(pci_lock_n), .pci_master_active(pci_master_active),
		.master_is_south(master_is_south), .target_is_peer(target_is_peer));

	// ----------------------------------------
	// shared tasks
	// ----------------------------------------
	task automatic apb(input logic wr, input logic [APB_AW-1:0] a, input logic [7:0] d);
		@(posedge core_clk);
		psel   <= 1'b1;
		pwrite <= wr;
		paddr  <= a;
		pwdata <= {24'h000000, d};
		@(posedge core_clk);
		penable <= 1'b1;
		// no wait count assumed: only the watchdog ends a stuck access
		do begin
			@(posedge core_clk);
		end while (pready !== 1'b1);
		q   = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] want);
		n_checks++;
		if (seen !== want) begin
			errors++;
			$display("unexpected at %0t: saw %h, wanted %h", $time, seen, want);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d, errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask

	// ----------------------------------------
	// clock, watchdog
	// ----------------------------------------
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end

	initial begin
		repeat (3000) @(posedge core_clk);
		errors++;
		complete_run;
	end

	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		rst = 1'b1;
		ce = 1'b1;
		psel = 1'b0;
		penable = 1'b0;
		pwrite = 1'b0;
		paddr = '0;
		pwdata = '0;
		pstrb = 4'hF;
		errors = 0;
		n_checks = 0;
		repeat (5) @(posedge core_clk);
		rst <= 1'b0;
		apb(1'b0, ARB_CTRL_ADDR, 8'h00);
		check(q, {24'h000000, ARB_CTRL_RST});
		apb(1'b0, PCI_FEAT_ADDR, 8'h00);
		check(q, {24'h000000, PCI_FEAT_RST});
		for (i = 0; i < 4; i++) begin
			u_far.master_cycle(1'b1, i[0], i[1]);
			check({31'h0, cpu_hold_off}, 32'h1);
		end
		u_far.master_cycle(1'b0, 1'b0, 1'b1);
		check({31'h0, cpu_hold_off}, 32'h0);
		u_far.bridge_cycle(1'b1, 1'b1, s);
		check({29'h0, s}, 32'h7);
		// companion bit assumed already set before this one
		apb(1'b1, ARB_CTRL_ADDR, 8'hFF);
		apb(1'b0, ARB_CTRL_ADDR, 8'h00);
		check(q, 32'h80);
		apb(1'b1, PCI_FEAT_ADDR, 8'hFF);
		apb(1'b0, PCI_FEAT_ADDR, 8'h00);
		check(q, 32'h08);
		for (i = 0; i < 4; i++) begin
			u_far.bridge_cycle(i[0], i[1], s);
			check({29'h0, s}, (i == 3) ? 32'h4 : 32'h6);
		end
		for (i = 0; i < 4; i++) begin
			u_far.master_cycle(1'b1, i[0], i[1]);
			check({31'h0, cpu_hold_off}, (i == 2) ? 32'h0 : 32'h1);
		end
		apb(1'b0, ARB_STATUS_ADDR, 8'h00);
		check(q, 32'h1);
		apb(1'b0, 12'h004, 8'h00);
		check({31'h0, err}, 32'h1);
		check(q, 32'h0);
		// a low clock enable must freeze the hold-off flop
		ce <= 1'b0;
		u_far.master_cycle(1'b0, 1'b0, 1'b0);
		check({31'h0, cpu_hold_off}, 32'h1);
		@(posedge core_clk);
		ce <= 1'b1;
		u_far.master_cycle(1'b0, 1'b0, 1'b0);
		check({31'h0, cpu_hold_off}, 32'h0);
		// this bit is cleared before the companion bit
		apb(1'b1, ARB_CTRL_ADDR, 8'h7F);
		u_far.bridge_cycle(1'b1, 1'b1, s);
		check({29'h0, s}, 32'h7);
		complete_run;
	end
endmodule
